// ---- src/csa_regs.sv ----
// register bank for two channels: measured value, condition, alarm word
// assumes an AXI4-Lite master, one clock, synchronous inputs
//
// What this block does
// (RULE1) scaled value word sits before status word
// (RULE2) status word ignores all bus writes
// (RULE3) status codes zero to eight as listed
// (RULE4) alarm word: four nibbles, alarm one lowest
// (RULE5) bits 0,4,8,12 show alarm active, read-only
// (RULE6) bits 1,5,9,13 show ack required, read-only
// (RULE7) bits 2,6,10,14 writable, written one acknowledges
// (RULE8) bits 3,7,11,15 spare
// (RULE9) written one clears pending ack; zero ignored
//
// Added by the designer: the AXI4-Lite interface to the registers.
module csa_regs #(
    parameter int ADDR_W = csa_pkg::AXI_ADDR_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire csa_pkg::csa_chan_in_t [csa_pkg::NUM_CH-1:0] chanIn,
    output logic [csa_pkg::NUM_CH-1:0][csa_pkg::ALARMS-1:0] ackPulse,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import csa_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    csa_state_t st_r;
    csa_state_t st_nxt;

    logic awTake;
    logic wTake;
    logic haveAw;
    logic haveW;
    logic doWrite;
    logic wrHit;
    logic rdHit;
    logic [IDX_W-1:0] wrIdx;
    logic [IDX_W-1:0] rdIdx;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [31:0] rdWord;
    logic [NUM_CH-1:0][15:0] alarmWord;
    logic [NUM_CH-1:0][3:0] condMap;
    logic [NUM_CH-1:0][ALARMS-1:0] ackClr;

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        ackClr = '0;

        // snapshot of the channel inputs; the bus never writes these
        for (int c = 0; c < NUM_CH; c++) begin
            st_nxt.chan[c].measured = chanIn[c].measuredQuantity; // RULE1
            // codes past the table are reported as an invalid reading
            if (chanIn[c].condition > COND_NO_DATA) begin // RULE3
                condMap[c] = COND_INVALID;
            end else begin
                condMap[c] = chanIn[c].condition;
            end
            st_nxt.chan[c].cond = condMap[c]; // RULE2
            st_nxt.chan[c].active = chanIn[c].alarmActive; // RULE5
            for (int a = 0; a < ALARMS; a++) begin // RULE4
                alarmWord[c][NIBBLE*a+BIT_ACTIVE] = st_r.chan[c].active[a]; // RULE5
                alarmWord[c][NIBBLE*a+BIT_ACKREQ] = st_r.chan[c].ackReq[a]; // RULE6
                alarmWord[c][NIBBLE*a+BIT_ACK] = st_r.chan[c].ackBits[a]; // RULE7
                alarmWord[c][NIBBLE*a+BIT_SPARE] = 1'b0; // RULE8
            end
        end

        // write path: address and data may arrive in either order
        awTake = s_axi_awvalid && st_r.awReady;
        wTake = s_axi_wvalid && st_r.wReady;
        haveAw = st_r.awHeld || awTake;
        haveW = st_r.wHeld || wTake;
        wrIdx = st_r.awHeld ? st_r.awIdx : IDX_W'(s_axi_awaddr >> 2);
        wrData = st_r.wHeld ? st_r.wData : s_axi_wdata;
        wrStrb = st_r.wHeld ? st_r.wStrb : s_axi_wstrb;
        wrHit = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (wrIdx == IDX_VALUE[c] || wrIdx == IDX_COND[c] || wrIdx == IDX_ALARM[c]) begin
                wrHit = 1'b1;
            end
        end

        if (st_r.bValid && s_axi_bready) begin
            st_nxt.bValid = 1'b0;
        end
        doWrite = haveAw && haveW && !st_r.bValid;
        if (doWrite) begin
            st_nxt.bValid = 1'b1;
            st_nxt.bResp = wrHit ? RESP_OKAY : RESP_SLVERR;
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld = 1'b0;
            // only the alarm word has writable bits; the rest take no effect
            for (int c = 0; c < NUM_CH; c++) begin
                if (wrIdx == IDX_ALARM[c]) begin
                    for (int a = 0; a < ALARMS; a++) begin
                        if (wrStrb[a/2]) begin
                            st_nxt.chan[c].ackBits[a] = wrData[NIBBLE*a+BIT_ACK]; // RULE7
                            ackClr[c][a] = wrData[NIBBLE*a+BIT_ACK] && st_r.chan[c].ackReq[a]; // RULE9
                        end
                    end
                end
            end
        end else begin
            st_nxt.awHeld = haveAw;
            st_nxt.wHeld = haveW;
            st_nxt.awIdx = wrIdx;
            st_nxt.wData = wrData;
            st_nxt.wStrb = wrStrb;
        end

        // a new alarm event wins over an acknowledge in the same cycle
        for (int c = 0; c < NUM_CH; c++) begin
            st_nxt.chan[c].ackReq = (st_r.chan[c].ackReq & ~ackClr[c]) | chanIn[c].ackReqEvent; // RULE6
            st_nxt.chan[c].ackPulse = ackClr[c]; // RULE9
        end
        st_nxt.awReady = !st_nxt.awHeld && !st_nxt.bValid;
        st_nxt.wReady = !st_nxt.wHeld && !st_nxt.bValid;

        // read path: one read at a time, answer the cycle after the take
        rdIdx = IDX_W'(s_axi_araddr >> 2);
        rdHit = 1'b0;
        rdWord = 32'h0000_0000;
        for (int c = 0; c < NUM_CH; c++) begin
            if (rdIdx == IDX_VALUE[c]) begin
                rdHit = 1'b1;
                rdWord = {16'h0000, st_r.chan[c].measured}; // RULE1
            end
            if (rdIdx == IDX_COND[c]) begin
                rdHit = 1'b1;
                rdWord = {28'h000_0000, st_r.chan[c].cond}; // RULE3
            end
            if (rdIdx == IDX_ALARM[c]) begin
                rdHit = 1'b1;
                rdWord = {16'h0000, alarmWord[c]}; // RULE4
            end
        end
        if (st_r.rValid && s_axi_rready) begin
            st_nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arReady) begin
            st_nxt.rValid = 1'b1;
            st_nxt.rData = rdWord;
            st_nxt.rResp = rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        st_nxt.arReady = !st_nxt.rValid;
    end

    // ----------------------------------------
    // state register; clkEn low freezes everything, but reset still loads ST_RESET
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= ST_RESET;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign s_axi_awready = st_r.awReady;
    assign s_axi_wready = st_r.wReady;
    assign s_axi_bvalid = st_r.bValid;
    assign s_axi_bresp = st_r.bResp;
    assign s_axi_arready = st_r.arReady;
    assign s_axi_rvalid = st_r.rValid;
    assign s_axi_rdata = st_r.rData;
    assign s_axi_rresp = st_r.rResp;
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            ackPulse[c] = st_r.chan[c].ackPulse;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    value_read_a: assert property ( // RULE1
        (clkEn && s_axi_arvalid && st_r.arReady && rdIdx == IDX_CH7_MEASURED_VALUE)
        |=> (s_axi_rvalid && s_axi_rdata == {16'h0000, $past(st_r.chan[0].measured)})
    ) else $error("value word read does not return measured quantity");

    cond_track_a: assert property ( // RULE2
        (clkEn && doWrite && wrIdx == IDX_CH7_COND)
        |=> (st_r.chan[0].cond == $past(condMap[0]) && s_axi_bresp == RESP_OKAY)
    ) else $error("condition word changed by bus write");

    cond_code_a: assert property ( // RULE3
        (clkEn && chanIn[1].condition > COND_NO_DATA) |=> (st_r.chan[1].cond == COND_INVALID)
    ) else $error("out of table condition not reported as invalid");

    alarm_layout_a: assert property ( // RULE5
        (clkEn && s_axi_arvalid && st_r.arReady && rdIdx == IDX_CH8_ALARM)
        |=> (s_axi_rdata[12] == $past(st_r.chan[1].active[3])
            && s_axi_rdata[0] == $past(st_r.chan[1].active[0]))
    ) else $error("alarm active bits misplaced");

    ack_set_a: assert property ( // RULE6
        (clkEn && chanIn[0].ackReqEvent[0]) |=> st_r.chan[0].ackReq[0]
    ) else $error("alarm event did not raise ack required");

    ack_store_a: assert property ( // RULE7
        (clkEn && doWrite && wrIdx == IDX_CH7_ALARM && wrStrb[1])
        |=> (st_r.chan[0].ackBits[3] == $past(wrData[14]))
    ) else $error("ack bit not stored");

    // value words may use all sixteen bits, so only alarm reads are checked
    spare_zero_a: assert property ( // RULE8
        (clkEn && s_axi_arvalid && st_r.arReady && (rdIdx == IDX_CH7_ALARM || rdIdx == IDX_CH8_ALARM))
        |=> (s_axi_rdata[3] == 1'b0 && s_axi_rdata[7] == 1'b0
            && s_axi_rdata[11] == 1'b0 && s_axi_rdata[15] == 1'b0)
    ) else $error("spare alarm bits read non-zero");

    ack_clear_a: assert property ( // RULE9
        (clkEn && doWrite && wrIdx == IDX_CH7_ALARM && wrStrb[0] && wrData[2]
            && st_r.chan[0].ackReq[0] && !chanIn[0].ackReqEvent[0])
        |=> (!st_r.chan[0].ackReq[0] && ackPulse[0][0]) ##1 !ackPulse[0][0] || !$past(clkEn, 1)
    ) else $error("written one did not clear ack required");

    ack_zero_a: assert property ( // RULE9
        (clkEn && doWrite && wrIdx == IDX_CH8_ALARM && wrStrb[0] && !wrData[2])
        |=> (st_r.chan[1].ackReq[0] == $past(st_r.chan[1].ackReq[0]) || $past(chanIn[1].ackReqEvent[0]))
    ) else $error("written zero changed ack required");

    write_resp_a: assert property (
        (s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready && clkEn)
        |=> s_axi_bvalid
    ) else $error("write response late");

endmodule

// ---- common/csa_pkg.sv ----
// package for the channel status and alarm register bank
// assumes a 40 MHz sys_clk and an AXI4-Lite master with 32-bit data
package csa_pkg;

    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int NUM_CH = 2;
    localparam int ALARMS = 4;
    localparam int AXI_ADDR_W = 18;
    localparam int IDX_W = 16;

    // ----------------------------------------
    // register indices; byte address is four times the index
    // ----------------------------------------
    localparam logic [IDX_W-1:0] IDX_CH7_MEASURED_VALUE = 16'hA1EB;
    localparam logic [IDX_W-1:0] IDX_CH7_COND = 16'hA1EC;
    localparam logic [IDX_W-1:0] IDX_CH7_ALARM = 16'hA1ED;
    localparam logic [IDX_W-1:0] IDX_CH8_MEASURED_VALUE = 16'hA1EE;
    localparam logic [IDX_W-1:0] IDX_CH8_COND = 16'hA1EF;
    localparam logic [IDX_W-1:0] IDX_CH8_ALARM = 16'hA1F0;
    localparam logic [IDX_W-1:0] IDX_VALUE [NUM_CH] = '{IDX_CH7_MEASURED_VALUE, IDX_CH8_MEASURED_VALUE};
    localparam logic [IDX_W-1:0] IDX_COND [NUM_CH] = '{IDX_CH7_COND, IDX_CH8_COND};
    localparam logic [IDX_W-1:0] IDX_ALARM [NUM_CH] = '{IDX_CH7_ALARM, IDX_CH8_ALARM};

    // ----------------------------------------
    // alarm word nibble layout
    // ----------------------------------------
    localparam int BIT_ACTIVE = 0;
    localparam int BIT_ACKREQ = 1;
    localparam int BIT_ACK = 2;
    localparam int BIT_SPARE = 3;
    localparam int NIBBLE = 4;

    // ----------------------------------------
    // bus answers
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // channel condition codes
    // ----------------------------------------
    typedef enum logic [3:0] {
        COND_GOOD = 4'h0,
        COND_DISABLED = 4'h1,
        COND_ABOVE_RANGE = 4'h2,
        COND_BELOW_RANGE = 4'h3,
        COND_HW_FAULT = 4'h4,
        COND_RANGING_FAULT = 4'h5,
        COND_OVERFLOW = 4'h6,
        COND_INVALID = 4'h7,
        COND_NO_DATA = 4'h8
    } csa_cond_t;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] measuredQuantity;
        logic [3:0] condition;
        logic [ALARMS-1:0] alarmActive;
        logic [ALARMS-1:0] ackReqEvent;
    } csa_chan_in_t;

    typedef struct packed {
        logic [15:0] measured;
        logic [3:0] cond;
        logic [ALARMS-1:0] active;
        logic [ALARMS-1:0] ackReq;
        logic [ALARMS-1:0] ackBits;
        logic [ALARMS-1:0] ackPulse;
    } csa_chan_st_t;

    typedef struct packed {
        logic awReady;
        logic wReady;
        logic awHeld;
        logic wHeld;
        logic [IDX_W-1:0] awIdx;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        csa_chan_st_t [NUM_CH-1:0] chan;
    } csa_state_t;

    // ----------------------------------------
    // values after reset
    // ----------------------------------------
    localparam csa_chan_st_t CHAN_RESET = '{cond: COND_NO_DATA, default: '0};
    localparam csa_state_t ST_RESET = '{
        awReady: 1'b1,
        wReady: 1'b1,
        arReady: 1'b1,
        chan: '{default: CHAN_RESET},
        default: '0
    };

endpackage

// ---- verif/csa_axi_master.sv ----
// remote polling master: AXI4-Lite register reads and writes
// assumes the csa_regs slave ports and one clock
module csa_axi_master (
    input wire logic sys_clk,
    output logic [csa_pkg::AXI_ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [csa_pkg::AXI_ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;
    import csa_pkg::*;
    logic hung = 1'b0;
    initial begin
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
    end
    // ack bits are written with ones to acknowledge
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        r = 2'h3;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) hung = 1'b1;
    endtask
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        d = '0;
        r = 2'h3;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) hung = 1'b1;
    endtask
endmodule

// ---- verif/tb_csa_regs.sv ----
// testbench for the channel status and alarm register bank
// assumes csa_pkg and the csa_axi_master partner
module tb_csa_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import csa_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clkEn = 1'b1;
    csa_chan_in_t [NUM_CH-1:0] chanIn = '0;
    logic [NUM_CH-1:0][ALARMS-1:0] ackPulse, pulseSeen;
    logic clrPulse = 1'b1;
    logic [AXI_ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    int badCount = 0;
    int checksDone = 0;
    logic [15:0] rowIdx [7] = '{16'hA1EB, 16'hA1EC, 16'hA1ED, 16'hA1EE, 16'hA1EF, 16'hA1F0, 16'hA1F1};
    logic [31:0] rowExp [7] = '{32'h0000_1234, 32'h0000_0002, 32'h0000_0101, 32'h0000_BEEF,
        32'h0000_0006, 32'h0000_1010, 32'h0000_0000};
    logic [1:0] rowResp [7] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
    always #12.5 sys_clk = ~sys_clk;
    // pulses last one cycle, so collect them
    always @(posedge sys_clk) pulseSeen <= clrPulse ? '0 : (pulseSeen | ackPulse);
    csa_regs DUT (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .chanIn(chanIn), .ackPulse(ackPulse),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    csa_axi_master M (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checksDone++;
        if (g !== e) begin
            badCount++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // a hung handshake ends the run at once
    task automatic guard;
        if (M.hung) begin
            badCount++;
            printVerdict();
        end
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
        M.rd(idx, got, resp);
        guard();
        chk(got, e);
        chk({30'h0, resp}, {30'h0, er});
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        M.wr(idx, d, resp);
        guard();
        chk({30'h0, resp}, {30'h0, er});
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        clrPulse <= 1'b0;
        chanIn[0] <= '{16'h1234, 4'h2, 4'b0101, 4'h0};
        chanIn[1] <= '{16'hBEEF, 4'h6, 4'b1010, 4'h0};
        for (int i = 0; i < 7; i++) rd(rowIdx[i], rowExp[i], rowResp[i]);
        $display("test rows done");
        for (int c = 0; c < 10; c++) begin
            chanIn[1].condition <= c[3:0];
            rd(IDX_CH8_COND, (c > 8) ? 32'h0000_0007 : c, RESP_OKAY);
        end
        $display("test codes done");
        @(posedge sys_clk);
        chanIn[0].ackReqEvent <= 4'b1001;
        chanIn[1].ackReqEvent <= 4'b0100;
        @(posedge sys_clk);
        chanIn[0].ackReqEvent <= 4'h0;
        chanIn[1].ackReqEvent <= 4'h0;
        rd(IDX_CH7_ALARM, 32'h0000_2103, RESP_OKAY);
        // read-only and spare bits written high too
        wr(IDX_CH7_ALARM, 32'h0000_8007, RESP_OKAY);
        rd(IDX_CH7_ALARM, 32'h0000_2105, RESP_OKAY);
        wr(IDX_CH7_ALARM, 32'h0000_0000, RESP_OKAY);
        rd(IDX_CH7_ALARM, 32'h0000_2101, RESP_OKAY);
        wr(IDX_CH8_ALARM, 32'h0000_0400, RESP_OKAY);
        rd(IDX_CH8_ALARM, 32'h0000_1410, RESP_OKAY);
        chk({24'h0, pulseSeen}, 32'h0000_0041);
        $display("test ack done");
        // an event seen while frozen must be lost
        clkEn <= 1'b0;
        chanIn[0].ackReqEvent <= 4'b0010;
        @(posedge sys_clk);
        chanIn[0].ackReqEvent <= 4'h0;
        clkEn <= 1'b1;
        rd(IDX_CH7_ALARM, 32'h0000_2101, RESP_OKAY);
        $display("test freeze done");
        wr(IDX_CH7_COND, 32'h0000_0005, RESP_OKAY);
        rd(IDX_CH7_COND, 32'h0000_0002, RESP_OKAY);
        wr(16'hA1F1, 32'h0000_0001, RESP_SLVERR);
        $display("test read-only done");
        // reset in mid-run drops pending acks and stored ack bits
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        rd(IDX_CH7_ALARM, 32'h0000_0101, RESP_OKAY);
        $display("test reset done");
        printVerdict();
    end
endmodule
